// *** design/rbw_dev_end.sv ***
// reset, boot and watchdog device end
// Behaviour
// [R1] straps sampled after reset release load general control
// [R2] flash boot: owner 1, boot 1, disable 0
// [R3] ddr boot: boot 0, disable 0, endian bit
// [R4] owner 0 frees serial port, enables slave
// [R5] mgmt slave enable switches its pins over
// [R6] debug select low routes test port debug
// [R7] cpu 500, ddr 312.5, rest 250 MHz
// [R8] core force resets cpu and subsystem
// [R9] cpu-only keeps dma, pcie, ddr running
// [R10] software stops frame dma before subsystem reset
// [R11] switch register bus slaves escape core reset
// [R12] chip soft reset bit resets whole device
// [R13] protect bit spares cpu and subsystem
// [R14] protected chip reset needs dma stopped first
// [R15] switch-only reset keeps serdes and pll running
// [R16] scratch and pin alt survive soft resets
// [R17] watchdog two seconds, off after reset
// [R18] timeout gives same reset as core force
// [R19] bad lock use fires reset immediately
// [R20] cause status updated only during cpu reset
// [R21] lock key written together with enable
// [R22] cpu-only also limits watchdog reset
// [R23] enable without correct key is misuse
`timescale 1ns/1ps
module rbw_dev_end import rbw_pkg::*; #(
	parameter int unsigned WD_TIMEOUT_CYC = WD_TIMEOUT_CYC_DEF
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// register link
	rbw_if.dev rb,
	// pins
	input wire logic [3:0] strap_i,
	input wire logic debug_select_n_i,
	// reset outputs
	output logic cpu_rst_o,
	output logic sys_rst_o,
	output logic ddr_rst_o,
	output logic switch_rst_o,
	output logic serdes_pll_rst_o,
	// configuration outputs
	output logic processor_disable_o,
	output logic boot_map_enable_o,
	output logic processor_big_endian_o,
	output logic serial_if_owner_o,
	output logic serial_slave_enable_o,
	output logic mgmt_slave_enable_o,
	output logic [7:0] pin_alt_function_o,
	output logic jtag_to_debug_o
);
	localparam logic [WD_CNT_W-1:0] WD_LAST = WD_CNT_W'(WD_TIMEOUT_CYC - 1);

	function automatic logic [4:0] gen_from_strap(input logic [3:0] s);
		logic [4:0] g;
		g = GEN_RST_VAL;
		if (s == STRAP_BOOT_LE || s == STRAP_BOOT_BE) begin
			g = '0;
			g[GEN_BOOT_BIT] = 1'b1;
			g[GEN_OWNER_BIT] = 1'b1;
			g[GEN_BE_BIT] = (s == STRAP_BOOT_BE);
		end else if (s == STRAP_MGMT_A0 || s == STRAP_MGMT_A31) begin
			g[GEN_MGMT_BIT] = 1'b1;
		end
		return g;
	endfunction : gen_from_strap

	logic [3:0] strap_s1_r, strap_s2_r;
	logic dbg_s1_r, dbg_s2_r;
	logic [2:0] strap_cnt_r;
	logic [4:0] strap_gen_r;
	logic [4:0] gen_r;
	logic cpu_only_r, protect_r;
	logic [31:0] scratch_r;
	logic [7:0] pinalt_r;
	logic wd_en_r, wd_stat_r;
	logic [WD_CNT_W-1:0] wd_cnt_r;
	rbw_seq_type seq_r;
	logic [3:0] seq_cnt_r;
	logic hit_cpu_r, hit_sys_r, hit_sw_r, hit_serdes_r, cause_wd_r;
	logic ack_r;
	logic [31:0] rdata_r;

	logic take, wr_gen, wr_rst, wr_soft, wr_wd, key_ok, wd_misuse, wd_fire;
	logic core_evt, chip_evt, cpu_in_rst, sub_clr;

	assign take = rb.req && !ack_r;
	assign wr_gen = take && rb.we && rb.addr == IDX_GEN;
	assign wr_rst = take && rb.we && rb.addr == IDX_RESET;
	assign wr_soft = take && rb.we && rb.addr == IDX_SOFT;
	assign wr_wd = take && rb.we && rb.addr == IDX_WD;
	assign key_ok = rb.wdata[WD_LOCK_LSB +: 8] == WD_LOCK_KEY;
	assign wd_misuse = wr_wd && rb.wdata[WD_EN_BIT] && !key_ok; // [R19] [R23]
	assign wd_fire = (wd_en_r && wd_cnt_r == WD_LAST) || wd_misuse; // [R18] [R19]
	assign core_evt = (wr_rst && rb.wdata[RST_FORCE_BIT]) || wd_fire; // [R8] [R18]
	assign chip_evt = wr_soft && (rb.wdata[SOFT_CHIP_BIT] || rb.wdata[SOFT_SWITCH_BIT]); // [R12] [R15]
	assign cpu_in_rst = seq_r == SEQ_RST && hit_cpu_r;
	assign sub_clr = seq_r == SEQ_RST && hit_sys_r && hit_sw_r;

	// pin synchronisers
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			strap_s1_r <= 4'h0;
			strap_s2_r <= 4'h0;
			dbg_s1_r <= 1'b1;
			dbg_s2_r <= 1'b1;
		end else begin
			strap_s1_r <= strap_i;
			strap_s2_r <= strap_s1_r;
			dbg_s1_r <= debug_select_n_i;
			dbg_s2_r <= dbg_s1_r;
		end
	end

	// strap capture shortly after release
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			strap_cnt_r <= 3'h0;
			strap_gen_r <= GEN_RST_VAL;
		end else if (strap_cnt_r != STRAP_DELAY_CYC) begin
			strap_cnt_r <= strap_cnt_r + 3'h1;
			if (strap_cnt_r == STRAP_DELAY_CYC - 3'h1) begin
				strap_gen_r <= gen_from_strap(strap_s2_r); // [R1]
			end
		end
	end

	// general control
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			gen_r <= GEN_RST_VAL;
		end else if (strap_cnt_r == STRAP_DELAY_CYC - 3'h1) begin
			gen_r <= gen_from_strap(strap_s2_r); // [R1]
		end else if (sub_clr) begin
			gen_r <= strap_gen_r; // [R1] [R13]
		end else if (wr_gen) begin
			gen_r <= rb.wdata[4:0]; // [R2] [R3] [R4] [R5]
		end
	end

	// reset protection options
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cpu_only_r <= 1'b0;
			protect_r <= 1'b0;
		end else if (sub_clr) begin
			cpu_only_r <= 1'b0;
			protect_r <= 1'b0;
		end else if (wr_rst) begin
			cpu_only_r <= rb.wdata[RST_CPU_ONLY_BIT];
			protect_r <= rb.wdata[RST_PROTECT_BIT];
		end
	end

	// scratch and pin alt, external reset only
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			scratch_r <= 32'h0;
			pinalt_r <= PINALT_RST_VAL;
		end else begin
			if (take && rb.we && rb.addr == IDX_SCRATCH) begin
				scratch_r <= rb.wdata; // [R16]
			end
			if (take && rb.we && rb.addr == IDX_PINALT) begin
				pinalt_r <= rb.wdata[7:0]; // [R16]
			end
		end
	end

	// watchdog
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wd_en_r <= 1'b0; // [R17]
			wd_cnt_r <= '0;
		end else if (cpu_in_rst) begin
			wd_en_r <= 1'b0;
			wd_cnt_r <= '0;
		end else if (wr_wd && key_ok) begin
			wd_en_r <= rb.wdata[WD_EN_BIT]; // [R21]
			wd_cnt_r <= '0;
		end else if (wd_en_r && wd_cnt_r != WD_LAST) begin
			wd_cnt_r <= wd_cnt_r + 1'b1; // [R17]
		end
	end

	// cause status, only while cpu held
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wd_stat_r <= 1'b0;
		end else if (cpu_in_rst) begin
			wd_stat_r <= cause_wd_r; // [R20]
		end
	end

	// soft reset sequencer
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			seq_r <= SEQ_RUN;
			seq_cnt_r <= 4'h0;
			hit_cpu_r <= 1'b0;
			hit_sys_r <= 1'b0;
			hit_sw_r <= 1'b0;
			hit_serdes_r <= 1'b0;
			cause_wd_r <= 1'b0;
		end else begin
			case (seq_r)
				SEQ_RUN: begin
					if (core_evt || chip_evt) begin
						seq_r <= SEQ_RST;
						seq_cnt_r <= RST_PULSE_CYC;
						hit_cpu_r <= core_evt || !protect_r; // [R8] [R13]
						hit_sys_r <= (core_evt && !cpu_only_r) || (chip_evt && !core_evt && !protect_r); // [R9] [R22]
						hit_sw_r <= chip_evt && !core_evt; // [R11] [R12]
						hit_serdes_r <= chip_evt && !core_evt && rb.wdata[SOFT_CHIP_BIT]; // [R15]
						cause_wd_r <= wd_fire;
					end
				end
				SEQ_RST: begin
					seq_cnt_r <= seq_cnt_r - 4'h1;
					if (seq_cnt_r == 4'h1) begin
						seq_r <= SEQ_RUN;
						hit_cpu_r <= 1'b0;
						hit_sys_r <= 1'b0;
						hit_sw_r <= 1'b0;
						hit_serdes_r <= 1'b0;
					end
				end
				default: begin
					seq_r <= SEQ_RUN;
				end
			endcase
		end
	end

	// register link answer
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ack_r <= 1'b0;
			rdata_r <= 32'h0;
		end else begin
			ack_r <= take;
			if (take) begin
				case (rb.addr)
					IDX_GEN: rdata_r <= {27'h0, gen_r};
					IDX_RESET: rdata_r <= {29'h0, protect_r, cpu_only_r, 1'b0};
					IDX_WD: rdata_r <= {30'h0, wd_stat_r, wd_en_r};
					IDX_SCRATCH: rdata_r <= scratch_r;
					IDX_PINALT: rdata_r <= {24'h0, pinalt_r};
					default: rdata_r <= 32'h0;
				endcase
			end
		end
	end
	assign rb.ack = ack_r;
	assign rb.rdata = rdata_r;

	// registered outputs, one per domain
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cpu_rst_o <= 1'b1;
			sys_rst_o <= 1'b1;
			ddr_rst_o <= 1'b1;
			switch_rst_o <= 1'b1;
			serdes_pll_rst_o <= 1'b1;
			processor_disable_o <= 1'b1;
			boot_map_enable_o <= 1'b0;
			processor_big_endian_o <= 1'b0;
			serial_if_owner_o <= 1'b0;
			serial_slave_enable_o <= 1'b1;
			mgmt_slave_enable_o <= 1'b0;
			pin_alt_function_o <= PINALT_RST_VAL;
			jtag_to_debug_o <= 1'b0;
		end else begin
			cpu_rst_o <= cpu_in_rst; // [R7] [R8]
			sys_rst_o <= seq_r == SEQ_RST && hit_sys_r; // [R7] [R9]
			ddr_rst_o <= seq_r == SEQ_RST && hit_sys_r; // [R7] [R9]
			switch_rst_o <= seq_r == SEQ_RST && hit_sw_r; // [R11] [R12]
			serdes_pll_rst_o <= seq_r == SEQ_RST && hit_serdes_r; // [R15]
			processor_disable_o <= gen_r[GEN_DIS_BIT];
			boot_map_enable_o <= gen_r[GEN_BOOT_BIT];
			processor_big_endian_o <= gen_r[GEN_BE_BIT];
			serial_if_owner_o <= gen_r[GEN_OWNER_BIT];
			serial_slave_enable_o <= !gen_r[GEN_OWNER_BIT]; // [R4]
			mgmt_slave_enable_o <= gen_r[GEN_MGMT_BIT]; // [R5]
			pin_alt_function_o <= pinalt_r | (gen_r[GEN_MGMT_BIT] ? MGMT_PIN_MASK : 8'h00); // [R5]
			jtag_to_debug_o <= !dbg_s2_r; // [R6]
		end
	end
endmodule : rbw_dev_end

// *** design/rbw_pkg.sv ***
// constants shared by the controller end and the device end
package rbw_pkg;
	// clocking and timing
	localparam int unsigned CLK_HZ = 20_000_000;
	localparam int unsigned WD_TIMEOUT_S = 2;
	localparam int unsigned WD_TIMEOUT_CYC_DEF = WD_TIMEOUT_S * CLK_HZ;
	localparam int unsigned WD_CNT_W = 26;
	localparam logic [3:0] RST_PULSE_CYC = 4'h8;
	localparam logic [2:0] STRAP_DELAY_CYC = 3'h4;
	// device register indexes
	localparam logic [3:0] IDX_GEN = 4'h0;
	localparam logic [3:0] IDX_RESET = 4'h1;
	localparam logic [3:0] IDX_SOFT = 4'h2;
	localparam logic [3:0] IDX_WD = 4'h3;
	localparam logic [3:0] IDX_SCRATCH = 4'h4;
	localparam logic [3:0] IDX_PINALT = 4'h5;
	// general control fields
	localparam int unsigned GEN_DIS_BIT = 0;
	localparam int unsigned GEN_BOOT_BIT = 1;
	localparam int unsigned GEN_BE_BIT = 2;
	localparam int unsigned GEN_OWNER_BIT = 3;
	localparam int unsigned GEN_MGMT_BIT = 4;
	localparam logic [4:0] GEN_RST_VAL = 5'h01;
	// straps
	localparam logic [3:0] STRAP_BOOT_LE = 4'h0;
	localparam logic [3:0] STRAP_BOOT_BE = 4'hc;
	localparam logic [3:0] STRAP_MGMT_A0 = 4'ha;
	localparam logic [3:0] STRAP_MGMT_A31 = 4'hb;
	// reset control fields
	localparam int unsigned RST_FORCE_BIT = 0;
	localparam int unsigned RST_CPU_ONLY_BIT = 1;
	localparam int unsigned RST_PROTECT_BIT = 2;
	localparam int unsigned SOFT_CHIP_BIT = 0;
	localparam int unsigned SOFT_SWITCH_BIT = 1;
	// watchdog fields
	localparam int unsigned WD_EN_BIT = 0;
	localparam int unsigned WD_STAT_BIT = 1;
	localparam int unsigned WD_LOCK_LSB = 8;
	localparam logic [7:0] WD_LOCK_KEY = 8'h5a;
	// pin alternate functions
	localparam logic [7:0] PINALT_RST_VAL = 8'h00;
	localparam logic [7:0] MGMT_PIN_MASK = 8'h03;
	// controller axi map
	localparam logic [11:0] A_CMD = 12'h000;
	localparam logic [11:0] A_WDATA = 12'h004;
	localparam logic [11:0] A_RDATA = 12'h008;
	localparam logic [11:0] A_STAT = 12'h00c;
	localparam logic [11:0] A_CTRL = 12'h010;
	localparam int unsigned CMD_IDX_LSB = 4;
	localparam int unsigned CMD_WE_BIT = 8;
	localparam logic [1:0] AXI_OKAY = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;
	// controller operations
	localparam logic [2:0] OP_RAW = 3'h0;
	localparam logic [2:0] OP_BOOT_FLASH = 3'h1;
	localparam logic [2:0] OP_BOOT_DDR = 3'h2;
	localparam logic [2:0] OP_WD_KICK = 3'h3;
	localparam logic [2:0] OP_CORE_RST = 3'h4;
	localparam logic [2:0] OP_CHIP_RST = 3'h5;
	localparam logic [2:0] OP_WD_STOP = 3'h6;
	typedef enum logic [1:0] {SEQ_RUN = 2'b01, SEQ_RST = 2'b10} rbw_seq_type;
	typedef enum logic [1:0] {H_IDLE = 2'b01, H_BUSY = 2'b10} rbw_host_type;
endpackage : rbw_pkg

// *** design/rbw_if.sv ***
// register link between the two ends
`timescale 1ns/1ps
interface rbw_if;
	logic req;
	logic we;
	logic [3:0] addr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic ack;
	modport dev (input req, input we, input addr, input wdata, output rdata, output ack);
	modport host (output req, output we, output addr, output wdata, input rdata, input ack);
endinterface : rbw_if

// *** design/rbw_host_end.sv ***
// controller end: axi4-lite to device link
`timescale 1ns/1ps
module rbw_host_end import rbw_pkg::*; (
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// register link
	rbw_if.host rb,
	// axi4-lite slave
	input wire logic [11:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [11:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	// frame dma run enable
	output logic fdma_enable_o
);
	function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (st[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction : apply_strb

	logic [11:0] aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	logic [31:0] wdata_reg_r, rdata_reg_r;
	rbw_host_type st_r;
	logic req_r, we_r;
	logic [3:0] addr_r;
	logic [31:0] lwdata_r;
	logic exec, go;
	logic [2:0] op;
	logic [31:0] gen_val;

	assign exec = !s_axi_awready_o && !s_axi_wready_o && !s_axi_bvalid_o;
	assign go = exec && aw_addr_r == A_CMD && st_r == H_IDLE;
	assign op = w_data_r[2:0];
	always_comb begin
		gen_val = 32'h0;
		gen_val[GEN_BE_BIT] = wdata_reg_r[GEN_BE_BIT]; // [R3]
		gen_val[GEN_MGMT_BIT] = wdata_reg_r[GEN_MGMT_BIT];
		gen_val[GEN_BOOT_BIT] = op == OP_BOOT_FLASH; // [R2] [R3]
		gen_val[GEN_OWNER_BIT] = op == OP_BOOT_FLASH; // [R2]
	end

	// axi write channels
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s_axi_awready_o <= 1'b1;
			s_axi_wready_o <= 1'b1;
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o <= AXI_OKAY;
			aw_addr_r <= 12'h0;
			w_data_r <= 32'h0;
			w_strb_r <= 4'h0;
		end else begin
			if (s_axi_awvalid_i && s_axi_awready_o) begin
				aw_addr_r <= s_axi_awaddr_i;
				s_axi_awready_o <= 1'b0;
			end
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				w_data_r <= s_axi_wdata_i;
				w_strb_r <= s_axi_wstrb_i;
				s_axi_wready_o <= 1'b0;
			end
			if (exec) begin
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o <= (aw_addr_r <= A_CTRL && aw_addr_r[1:0] == 2'h0) ? AXI_OKAY : AXI_SLVERR;
			end
			if (s_axi_bvalid_o && s_axi_bready_i) begin
				s_axi_bvalid_o <= 1'b0;
				s_axi_awready_o <= 1'b1;
				s_axi_wready_o <= 1'b1;
			end
		end
	end

	// write data holding and dma enable
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wdata_reg_r <= 32'h0;
			fdma_enable_o <= 1'b0;
		end else begin
			if (exec && aw_addr_r == A_WDATA) begin
				wdata_reg_r <= apply_strb(wdata_reg_r, w_data_r, w_strb_r);
			end
			if (exec && aw_addr_r == A_CTRL && w_strb_r[0]) begin
				fdma_enable_o <= w_data_r[0];
			end else if (go && (op == OP_CORE_RST || op == OP_CHIP_RST)) begin
				fdma_enable_o <= 1'b0; // [R10] [R14]
			end
		end
	end

	// device link requests
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_r <= H_IDLE;
			req_r <= 1'b0;
			we_r <= 1'b0;
			addr_r <= 4'h0;
			lwdata_r <= 32'h0;
			rdata_reg_r <= 32'h0;
		end else begin
			case (st_r)
				H_IDLE: begin
					if (go) begin
						st_r <= H_BUSY;
						req_r <= 1'b1;
						we_r <= 1'b1;
						lwdata_r <= wdata_reg_r;
						case (op)
							OP_RAW: begin
								we_r <= w_data_r[CMD_WE_BIT];
								addr_r <= w_data_r[CMD_IDX_LSB +: 4];
							end
							OP_BOOT_FLASH, OP_BOOT_DDR: begin
								addr_r <= IDX_GEN;
								lwdata_r <= gen_val; // [R2] [R3]
							end
							OP_WD_KICK: begin
								addr_r <= IDX_WD;
								lwdata_r <= {16'h0, WD_LOCK_KEY, 8'h01}; // [R21] [R18]
							end
							OP_WD_STOP: begin
								addr_r <= IDX_WD;
								lwdata_r <= {16'h0, WD_LOCK_KEY, 8'h00};
							end
							OP_CORE_RST: begin
								addr_r <= IDX_RESET;
							end
							OP_CHIP_RST: begin
								addr_r <= IDX_SOFT;
							end
							default: begin
								addr_r <= w_data_r[CMD_IDX_LSB +: 4];
								we_r <= 1'b0;
							end
						endcase
					end
				end
				H_BUSY: begin
					if (rb.ack) begin
						req_r <= 1'b0;
						rdata_reg_r <= rb.rdata;
						st_r <= H_IDLE;
					end
				end
				default: begin
					st_r <= H_IDLE;
					req_r <= 1'b0;
				end
			endcase
		end
	end
	assign rb.req = req_r;
	assign rb.we = we_r;
	assign rb.addr = addr_r;
	assign rb.wdata = lwdata_r;

	// axi read channel
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s_axi_arready_o <= 1'b1;
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o <= 32'h0;
			s_axi_rresp_o <= AXI_OKAY;
		end else begin
			if (s_axi_arvalid_i && s_axi_arready_o) begin
				s_axi_arready_o <= 1'b0;
				s_axi_rvalid_o <= 1'b1;
				s_axi_rresp_o <= AXI_OKAY;
				case (s_axi_araddr_i)
					A_CMD: s_axi_rdata_o <= 32'h0;
					A_WDATA: s_axi_rdata_o <= wdata_reg_r;
					A_RDATA: s_axi_rdata_o <= rdata_reg_r;
					A_STAT: s_axi_rdata_o <= {31'h0, st_r == H_BUSY};
					A_CTRL: s_axi_rdata_o <= {31'h0, fdma_enable_o};
					default: begin
						s_axi_rdata_o <= 32'h0;
						s_axi_rresp_o <= AXI_SLVERR;
					end
				endcase
			end
			if (s_axi_rvalid_o && s_axi_rready_i) begin
				s_axi_rvalid_o <= 1'b0;
				s_axi_arready_o <= 1'b1;
			end
		end
	end
endmodule : rbw_host_end

// *** testbench/rbw_link_monitor.sv ***
// assertions on the device link and outputs
`timescale 1ns/1ps
module rbw_link_monitor import rbw_pkg::*; (
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// link
	input wire logic req,
	input wire logic we,
	input wire logic [3:0] addr,
	input wire logic [31:0] wdata,
	input wire logic ack,
	// device pins
	input wire logic debug_select_n_i,
	input wire logic cpu_rst_o,
	input wire logic sys_rst_o,
	input wire logic ddr_rst_o,
	input wire logic switch_rst_o,
	input wire logic serdes_pll_rst_o,
	input wire logic serial_if_owner_o,
	input wire logic serial_slave_enable_o,
	input wire logic mgmt_slave_enable_o,
	input wire logic [7:0] pin_alt_function_o,
	input wire logic jtag_to_debug_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	logic tk, quiet;
	assign tk = req && !ack && we;
	assign quiet = !(cpu_rst_o || sys_rst_o || ddr_rst_o || switch_rst_o || serdes_pll_rst_o);
	AST_CORE_FORCE: assert property (tk && quiet && addr == IDX_RESET && wdata[RST_FORCE_BIT]
		|-> ##2 (cpu_rst_o && !switch_rst_o)) else $error("core force");
	AST_PULSE_LEN: assert property ($rose(cpu_rst_o) |-> cpu_rst_o [*8] ##1 !cpu_rst_o)
		else $error("pulse length");
	AST_SWITCH_ONLY: assert property (tk && quiet && addr == IDX_SOFT && wdata[1:0] == 2'b10
		|-> ##2 (switch_rst_o && !serdes_pll_rst_o)) else $error("switch-only");
	AST_CHIP_RST: assert property (tk && quiet && addr == IDX_SOFT && wdata[SOFT_CHIP_BIT]
		|-> ##2 (switch_rst_o && serdes_pll_rst_o)) else $error("chip reset");
	AST_WD_BADKEY: assert property (tk && quiet && addr == IDX_WD && wdata[WD_EN_BIT]
		&& wdata[15:8] != WD_LOCK_KEY |-> ##2 cpu_rst_o) else $error("bad key");
	AST_SYS_WITH_CPU: assert property ($rose(sys_rst_o) |-> cpu_rst_o && ddr_rst_o)
		else $error("system reset");
	AST_SERDES_CHIP: assert property ($rose(serdes_pll_rst_o) |-> switch_rst_o)
		else $error("serdes reset");
	AST_OWNER_SLAVE: assert property ($changed(serial_if_owner_o)
		|-> ##[0:1] (serial_slave_enable_o != serial_if_owner_o)) else $error("serial slave");
	AST_MGMT_PINS: assert property ($rose(mgmt_slave_enable_o)
		|-> ##[0:1] ((pin_alt_function_o & MGMT_PIN_MASK) == MGMT_PIN_MASK)) else $error("mgmt pins");
	AST_DEBUG_ROUTE: assert property ($fell(debug_select_n_i) |-> ##[1:5] jtag_to_debug_o)
		else $error("debug route");
	cover property (tk && addr == IDX_WD);
	cover property ($rose(serdes_pll_rst_o));
	cover property ($rose(cpu_rst_o) && !sys_rst_o);
endmodule : rbw_link_monitor

// *** testbench/tb_top.sv ***
// self-checking bench for both ends
`timescale 1ns/1ps
module tb_top import rbw_pkg::*;;
	logic clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic [3:0] strap_i = STRAP_BOOT_BE;
	logic debug_select_n_i = 1'b1;
	logic [11:0] aw = '0;
	logic [11:0] ar = '0;
	logic [31:0] wd = '0;
	logic awv = 1'b0, wv = 1'b0, brd = 1'b0, arv = 1'b0, rrd = 1'b0;
	logic awr, wrdy, bv, arr, rv, fdma;
	logic [1:0] br, rr;
	logic [31:0] rd;
	logic cpu_rst_o, sys_rst_o, ddr_rst_o, switch_rst_o, serdes_pll_rst_o, processor_disable_o;
	logic boot_map_enable_o, processor_big_endian_o, serial_if_owner_o, serial_slave_enable_o;
	logic mgmt_slave_enable_o, jtag_to_debug_o;
	logic [7:0] pin_alt_function_o;
	logic [33:0] exp_q[$], msk_q[$];
	logic [31:0] seed = 32'ha8ec;
	logic [31:0] sc;
	logic [7:0] pa = 8'h00;
	int error_cnt = 0;
	int comparisons = 0;
	int cnt[5] = '{default: 0};
	wire [4:0] rvec = {cpu_rst_o, sys_rst_o, ddr_rst_o, switch_rst_o, serdes_pll_rst_o};
	rbw_if u_rbw_if ();
	rbw_host_end u_rbw_host_end (.clk_i, .nrst_i, .rb(u_rbw_if.host), .s_axi_awaddr_i(aw), .s_axi_awvalid_i(awv),
		.s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrdy),
		.s_axi_bresp_o(br), .s_axi_bvalid_o(bv), .s_axi_bready_i(brd), .s_axi_araddr_i(ar), .s_axi_arvalid_i(arv),
		.s_axi_arready_o(arr), .s_axi_rdata_o(rd), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv), .s_axi_rready_i(rrd),
		.fdma_enable_o(fdma));
	rbw_dev_end #(.WD_TIMEOUT_CYC(64)) u_rbw_dev_end (.clk_i, .nrst_i, .rb(u_rbw_if.dev), .strap_i,
		.debug_select_n_i, .cpu_rst_o, .sys_rst_o, .ddr_rst_o, .switch_rst_o, .serdes_pll_rst_o, .processor_disable_o,
		.boot_map_enable_o, .processor_big_endian_o, .serial_if_owner_o, .serial_slave_enable_o,
		.mgmt_slave_enable_o, .pin_alt_function_o, .jtag_to_debug_o);
	rbw_link_monitor u_rbw_link_monitor (.clk_i, .nrst_i, .req(u_rbw_if.req), .we(u_rbw_if.we),
		.addr(u_rbw_if.addr), .wdata(u_rbw_if.wdata), .ack(u_rbw_if.ack), .debug_select_n_i, .cpu_rst_o, .sys_rst_o,
		.ddr_rst_o, .switch_rst_o, .serdes_pll_rst_o, .serial_if_owner_o, .serial_slave_enable_o,
		.mgmt_slave_enable_o, .pin_alt_function_o, .jtag_to_debug_o);
	always #25 clk_i = ~clk_i;
	// pulse counters
	always @(posedge clk_i) begin
		for (int i = 0; i < 5; i++) if (nrst_i && rvec[i] === 1'b1) cnt[i]++;
	end
	function automatic logic [31:0] xs(input logic [31:0] x);
		logic [31:0] y;
		y = x ^ (x << 13);
		y = y ^ (y >> 17);
		return y ^ (y << 5);
	endfunction : xs
	task automatic summarize();
		$display("comparisons %0d errors %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : summarize
	task automatic tmo();
		error_cnt++;
		$display("[ERR] wait exp answer got timeout");
		summarize();
	endtask : tmo
	task automatic cmp_rd(input logic [33:0] e, input logic [33:0] g, input logic [33:0] m);
		comparisons++;
		if ((g & m) !== (e & m)) begin
			error_cnt++;
			$display("[ERR] axi answer exp %h got %h", e & m, g);
		end
	endtask : cmp_rd
	task automatic cmp_out(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask : cmp_out
	// answer watcher
	always @(posedge clk_i) begin
		if ((rv && rrd) || (bv && brd)) begin
			if (exp_q.size() == 0) begin
				error_cnt++;
				$display("[ERR] axi answer exp none got %h", rd);
			end else
				cmp_rd(exp_q.pop_front(), (rv && rrd) ? {rr, rd} : {br, 32'h0}, msk_q.pop_front());
		end
	end
	task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] resp);
		int n;
		exp_q.push_back({resp, 32'h0});
		msk_q.push_back(34'h3_0000_0000);
		aw <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		brd <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk_i);
			if (awr) awv <= 1'b0;
			if (wrdy) wv <= 1'b0;
			if (bv) break;
		end
		brd <= 1'b0;
		@(posedge clk_i);
		if (n == 50) tmo();
	endtask : axw
	task automatic axr(input logic [11:0] a, input logic [33:0] e, input logic [33:0] m, output logic [31:0] q);
		int n;
		exp_q.push_back(e);
		msk_q.push_back(m);
		ar <= a;
		arv <= 1'b1;
		rrd <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk_i);
			if (arr) arv <= 1'b0;
			q = rd;
			if (rv) break;
		end
		rrd <= 1'b0;
		@(posedge clk_i);
		if (n == 50) tmo();
	endtask : axr
	task automatic dev(input logic [2:0] op, input logic [3:0] idx, input logic w, input logic [31:0] d);
		logic [31:0] s;
		int n;
		axw(A_WDATA, d, AXI_OKAY);
		axw(A_CMD, {23'h0, w, idx, 1'b0, op}, AXI_OKAY);
		for (n = 0; n < 20; n++) begin
			axr(A_STAT, 34'h0, 34'h3_0000_0000, s);
			if (s[0] === 1'b0) break;
		end
		if (n == 20) tmo();
	endtask : dev
	task automatic rdreg(input logic [3:0] idx, input logic [31:0] e, input logic [31:0] m);
		logic [31:0] s;
		dev(3'h7, idx, 1'b0, 32'h0);
		axr(A_RDATA, {AXI_OKAY, e}, {2'h3, m}, s);
	endtask : rdreg
	task automatic op_rst(input logic [2:0] op, input logic [3:0] idx, input logic [31:0] d, input logic [19:0] e,
		input int w);
		int s[5];
		logic [19:0] g;
		s = cnt;
		dev(op, idx, op == OP_RAW, d);
		repeat (w) @(posedge clk_i);
		for (int i = 0; i < 5; i++) g[4*i +: 4] = 4'(cnt[i] - s[i]);
		cmp_out("pulses", {12'h0, e}, {12'h0, g});
	endtask : op_rst
	task automatic gen_chk(input logic [4:0] g);
		logic [31:0] p;
		p = {18'h0, pa | (g[4] ? MGMT_PIN_MASK : 8'h00), !g[3], g};
		rdreg(IDX_GEN, {27'h0, g}, 32'h1f);
		cmp_out("pins", p, {18'h0, pin_alt_function_o, serial_slave_enable_o, mgmt_slave_enable_o,
			serial_if_owner_o, processor_big_endian_o, boot_map_enable_o, processor_disable_o});
	endtask : gen_chk
	task automatic do_reset(input logic [3:0] s);
		nrst_i <= 1'b0;
		strap_i <= s;
		repeat (20) @(posedge clk_i);
		nrst_i <= 1'b1;
		repeat (8) @(posedge clk_i);
	endtask : do_reset
	logic [4:0] gv[4] = '{5'h01, 5'h10, 5'h0e, 5'h00};
	logic [31:0] t;
	initial begin
		do_reset(STRAP_BOOT_BE);
		gen_chk(5'h0e);
		rdreg(IDX_WD, 32'h0, 32'h3);
		seed = xs(seed);
		sc = seed;
		op_rst(OP_RAW, IDX_SCRATCH, sc, 20'h0, 90);
		seed = xs(seed);
		pa = seed[7:0];
		dev(OP_RAW, IDX_PINALT, 1'b1, {24'h0, pa});
		$display("straps done");
		foreach (gv[i]) begin
			dev(OP_RAW, IDX_GEN, 1'b1, {27'h0, gv[i]});
			gen_chk(gv[i]);
		end
		dev(OP_BOOT_FLASH, 4'h0, 1'b0, 32'h0);
		gen_chk(5'h0a);
		dev(OP_BOOT_DDR, 4'h0, 1'b0, 32'h0);
		gen_chk(5'h00);
		$display("boot done");
		axw(A_CTRL, 32'h1, AXI_OKAY);
		cmp_out("dma enable", 32'h1, {31'h0, fdma});
		op_rst(OP_CORE_RST, 4'h0, 32'h1, 20'h88800, 30);
		cmp_out("dma enable", 32'h0, {31'h0, fdma});
		rdreg(IDX_WD, 32'h0, 32'h3);
		dev(OP_RAW, IDX_RESET, 1'b1, 32'h2);
		op_rst(OP_CORE_RST, 4'h0, 32'h3, 20'h80000, 30);
		op_rst(OP_WD_KICK, 4'h0, 32'h0, 20'h80000, 100);
		rdreg(IDX_WD, 32'h2, 32'h3);
		$display("core done");
		dev(OP_RAW, IDX_RESET, 1'b1, 32'h4);
		op_rst(OP_CHIP_RST, 4'h0, 32'h1, 20'h00088, 30);
		rdreg(IDX_PINALT, {24'h0, pa}, 32'hff);
		dev(OP_RAW, IDX_RESET, 1'b1, 32'h0);
		op_rst(OP_CHIP_RST, 4'h0, 32'h2, 20'h88880, 30);
		gen_chk(5'h0e);
		op_rst(OP_CHIP_RST, 4'h0, 32'h1, 20'h88888, 30);
		rdreg(IDX_SCRATCH, sc, 32'hffffffff);
		$display("chip done");
		op_rst(OP_RAW, IDX_WD, 32'h0000_0001, 20'h88800, 30);
		rdreg(IDX_WD, 32'h2, 32'h3);
		op_rst(OP_RAW, IDX_WD, 32'h0000_3300, 20'h0, 30);
		dev(OP_WD_KICK, 4'h0, 1'b0, 32'h0);
		repeat (40) @(posedge clk_i);
		dev(OP_WD_KICK, 4'h0, 1'b0, 32'h0);
		repeat (40) @(posedge clk_i);
		op_rst(OP_WD_STOP, 4'h0, 32'h0, 20'h0, 90);
		op_rst(OP_RAW, IDX_WD, {16'h0, WD_LOCK_KEY, 8'h01}, 20'h88800, 100);
		$display("watchdog done");
		debug_select_n_i <= 1'b0;
		repeat (6) @(posedge clk_i);
		cmp_out("debug route", 32'h1, {31'h0, jtag_to_debug_o});
		debug_select_n_i <= 1'b1;
		repeat (6) @(posedge clk_i);
		cmp_out("debug route", 32'h0, {31'h0, jtag_to_debug_o});
		axr(12'h020, {AXI_SLVERR, 32'h0}, '1, t);
		axw(12'h020, 32'h1, AXI_SLVERR);
		rdreg(4'hf, 32'h0, 32'hffffffff);
		$display("debug done");
		do_reset(STRAP_MGMT_A0);
		pa = 8'h00;
		gen_chk(5'h11);
		rdreg(IDX_SCRATCH, 32'h0, 32'hffffffff);
		$display("reset done");
		summarize();
	end
endmodule : tb_top
